// [shared/fsl_pkg.sv]
`default_nettype none
package fsl_pkg;
	// Register bank codes (bank letter A..I as 0..8)
	localparam logic [3:0] BANK_A            = 4'h0;
	localparam logic [3:0] BANK_B            = 4'h1;
	// Register offsets inside their bank
	localparam logic [7:0] OFS_PAD_EN        = 8'h25;
	localparam logic [7:0] OFS_LOCK_CTRL     = 8'h0A;
	localparam logic [7:0] OFS_ROW_TGT_HI    = 8'h50;
	localparam logic [7:0] OFS_ROW_TGT_LO    = 8'h51;
	localparam logic [7:0] OFS_COL_TGT_HI    = 8'h52;
	localparam logic [7:0] OFS_COL_TGT_LO    = 8'h53;
	localparam logic [7:0] OFS_PULSE_WIDTH   = 8'h54;
	localparam logic [7:0] OFS_UPDATE_STROBE = 8'h59;
	// Field positions
	localparam int BIT_PAD_EN      = 0;
	localparam int BIT_ROLE        = 4;
	localparam int BIT_LOCK_EN     = 5;
	localparam int BIT_UPDATE      = 0;
	localparam int TGT_HI_W        = 5;
	localparam int TGT_LO_W        = 8;
	localparam int TGT_W           = TGT_HI_W + TGT_LO_W;
	localparam int PW_W            = 8;
	// Reset values
	localparam logic             RST_PAD_EN  = 1'b0;
	localparam logic             RST_LOCK_EN = 1'b0;
	localparam logic             RST_ROLE    = 1'b0;
	localparam logic [TGT_W-1:0] RST_ROW_TGT = 13'h0001;
	localparam logic [TGT_W-1:0] RST_COL_TGT = 13'h0001;
	localparam logic [PW_W-1:0]  RST_PW      = 8'h10;
	// Least pulse the master drives, in pixel clocks
	localparam logic [PW_W-1:0]  MIN_PW      = 8'h04;

	typedef struct packed {
		logic             lock_en;
		logic             master;
		logic [TGT_W-1:0] row_tgt;
		logic [TGT_W-1:0] col_tgt;
		logic [PW_W-1:0]  width;
	} fsl_cfg_t;

	localparam fsl_cfg_t RST_CFG = '{
		lock_en: RST_LOCK_EN,
		master:  RST_ROLE,
		row_tgt: RST_ROW_TGT,
		col_tgt: RST_COL_TGT,
		width:   RST_PW
	};

	typedef enum logic {
		PG_IDLE  = 1'b0,
		PG_DRIVE = 1'b1
	} fsl_pg_t;
endpackage
`default_nettype wire

// [rtl/fsl_frame_sync_lock.sv]
// Overview of operation
// [R1] Master drives the sync pulse on the pad; slave takes pad as reference.
// [R2] A master pulse stays high at least four pixel clocks.
// [R3] Master starts the pulse when row and column hit their targets.
// [R4] Master holds the pulse high for the programmed width in clocks.
// [R5] Slave on pulse rise loads row target and column target plus one.
// [R6] Pad enable at bit zero gates the pad; resets to disabled.
// [R7] Lock enable at bit five switches locking on; resets off.
// [R8] Role bit four selects slave at zero, master at one; resets slave.
// [R9] Row target is 13 bits from 5 high and 8 low; resets to one.
// [R10] Column target is 13 bits from 5 high and 8 low; resets to one.
// [R11] Pulse width is 8 bits in pixel clocks; resets to sixteen.
// [R12] With update strobe set, new lock settings apply from next frame.
// [R13] Counters advance each clock, wrapping at frame width and height.
// [R14] With lock or pad disabled, no pulse driven and no reload.
`timescale 1ns/1ps
`default_nettype none
module fsl_frame_sync_lock
	import fsl_pkg::*;
#(
	parameter int FRAME_W = 2200,
	parameter int FRAME_H = 1125
)
(
	// Clock, reset, enable
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              ce,
	// Register port
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [3:0]        reg_bank,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	output var  logic [7:0]        reg_rdata,
	// Sync pad
	input  wire logic              sync_pad_in,
	output var  logic              sync_pad_out,
	output var  logic              sync_pad_oe_n,
	// Timing state
	output var  logic [TGT_W-1:0]  row_count,
	output var  logic [TGT_W-1:0]  col_count,
	output var  logic              frame_start
);

	// Counters cannot hold frames this large or this small
	if (FRAME_W < 2 || FRAME_W > (1 << TGT_W) ||
	    FRAME_H < 2 || FRAME_H > (1 << TGT_W))
	begin : g_size_check
		$error("fsl_frame_sync_lock: frame size out of range");
	end

	localparam logic [TGT_W-1:0] COL_LAST = TGT_W'(FRAME_W - 1);
	localparam logic [TGT_W-1:0] ROW_LAST = TGT_W'(FRAME_H - 1);

	function automatic logic hit(input logic [3:0] b, input logic [7:0] a,
	                             input logic [3:0] wb, input logic [7:0] wa);
		hit = (b == wb) && (a == wa);
	endfunction

	// Registers: staged settings, active settings, strobe
	logic             pad_en_q, pad_en_d;
	fsl_cfg_t         stage_q, stage_d;
	fsl_cfg_t         act_q, act_d;
	logic             upd_q, upd_d;
	logic [7:0]       rdata_q, rdata_d;

	// Pad input synchroniser and filtered level
	logic             s1_q, s2_q, s3_q, lvl_q;
	logic             lvl_d;
	logic             rise;

	// Counters and pulse generator
	logic [TGT_W-1:0] row_q, row_d, col_q, col_d;
	logic             fs_q, fs_d;
	fsl_pg_t          pg_q, pg_d;
	logic [PW_W-1:0]  pcnt_q, pcnt_d;

	logic             wr_ctrl, wr_strobe;
	logic             lock_live, is_master, is_slave, frame_end;
	logic [PW_W-1:0]  eff_w;
	logic [TGT_W-1:0] col_load;

	assign lock_live = act_q.lock_en && pad_en_q;         // [R14] [R6] [R7]
	assign is_master = lock_live && act_q.master;          // [R8]
	assign is_slave  = lock_live && !act_q.master;         // [R8]
	assign frame_end = (col_q == COL_LAST) && (row_q == ROW_LAST);
	assign eff_w = (act_q.width < MIN_PW) ? MIN_PW : act_q.width; // [R2]
	assign col_load = (act_q.col_tgt >= COL_LAST) ? '0 :
	                  act_q.col_tgt + TGT_W'(1);           // [R5]
	assign wr_strobe = reg_wr && hit(reg_bank, reg_addr, BANK_B,
	                                 OFS_UPDATE_STROBE);

	// Register write and read path
	always_comb
	begin
		pad_en_d = pad_en_q;
		stage_d  = stage_q;
		upd_d    = upd_q;
		rdata_d  = rdata_q;
		wr_ctrl  = 1'b0;
		if (reg_wr)
		begin
			wr_ctrl = 1'b1;
			if (hit(reg_bank, reg_addr, BANK_A, OFS_PAD_EN))
				pad_en_d = reg_wdata[BIT_PAD_EN];       // [R6]
			else if (hit(reg_bank, reg_addr, BANK_B, OFS_LOCK_CTRL))
			begin
				stage_d.lock_en = reg_wdata[BIT_LOCK_EN]; // [R7]
				stage_d.master  = reg_wdata[BIT_ROLE];    // [R8]
			end
			else if (hit(reg_bank, reg_addr, BANK_B, OFS_ROW_TGT_HI))
				stage_d.row_tgt[TGT_W-1:TGT_LO_W] =
					reg_wdata[TGT_HI_W-1:0];              // [R9]
			else if (hit(reg_bank, reg_addr, BANK_B, OFS_ROW_TGT_LO))
				stage_d.row_tgt[TGT_LO_W-1:0] = reg_wdata; // [R9]
			else if (hit(reg_bank, reg_addr, BANK_B, OFS_COL_TGT_HI))
				stage_d.col_tgt[TGT_W-1:TGT_LO_W] =
					reg_wdata[TGT_HI_W-1:0];              // [R10]
			else if (hit(reg_bank, reg_addr, BANK_B, OFS_COL_TGT_LO))
				stage_d.col_tgt[TGT_LO_W-1:0] = reg_wdata; // [R10]
			else if (hit(reg_bank, reg_addr, BANK_B, OFS_PULSE_WIDTH))
				stage_d.width = reg_wdata;                // [R11]
			else
				wr_ctrl = 1'b0;
		end
		// Frame boundary consumes the strobe; a write in that cycle wins
		if (upd_q && frame_end)
			upd_d = 1'b0;                                 // [R12]
		if (wr_strobe)
			upd_d = reg_wdata[BIT_UPDATE];                // [R12]
		if (reg_rd)
		begin
			rdata_d = 8'h00;
			if (hit(reg_bank, reg_addr, BANK_A, OFS_PAD_EN))
				rdata_d[BIT_PAD_EN] = pad_en_q;
			else if (hit(reg_bank, reg_addr, BANK_B, OFS_LOCK_CTRL))
			begin
				rdata_d[BIT_LOCK_EN] = stage_q.lock_en;
				rdata_d[BIT_ROLE]    = stage_q.master;
			end
			else if (hit(reg_bank, reg_addr, BANK_B, OFS_ROW_TGT_HI))
				rdata_d[TGT_HI_W-1:0] = stage_q.row_tgt[TGT_W-1:TGT_LO_W];
			else if (hit(reg_bank, reg_addr, BANK_B, OFS_ROW_TGT_LO))
				rdata_d = stage_q.row_tgt[TGT_LO_W-1:0];
			else if (hit(reg_bank, reg_addr, BANK_B, OFS_COL_TGT_HI))
				rdata_d[TGT_HI_W-1:0] = stage_q.col_tgt[TGT_W-1:TGT_LO_W];
			else if (hit(reg_bank, reg_addr, BANK_B, OFS_COL_TGT_LO))
				rdata_d = stage_q.col_tgt[TGT_LO_W-1:0];
			else if (hit(reg_bank, reg_addr, BANK_B, OFS_PULSE_WIDTH))
				rdata_d = stage_q.width;
			else if (hit(reg_bank, reg_addr, BANK_B, OFS_UPDATE_STROBE))
				rdata_d[BIT_UPDATE] = upd_q;
		end
	end

	// Active settings follow staged ones at once, or at frame end
	always_comb
	begin
		act_d = act_q;
		if (upd_q)
		begin
			if (frame_end)
				act_d = stage_q;                          // [R12]
		end
		else if (!wr_ctrl)
			act_d = stage_q;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			pad_en_q <= RST_PAD_EN;
			stage_q  <= RST_CFG;
			act_q    <= RST_CFG;
			upd_q    <= 1'b0;
			rdata_q  <= 8'h00;
		end
		else if (ce)
		begin
			pad_en_q <= pad_en_d;
			stage_q  <= stage_d;
			act_q    <= act_d;
			upd_q    <= upd_d;
			rdata_q  <= rdata_d;
		end
	end

	// Pad level counts once second and third stages agree
	assign rise = (s2_q == s3_q) && s3_q && !lvl_q;
	always_comb
	begin
		lvl_d = lvl_q;
		if (s2_q == s3_q)
			lvl_d = s3_q;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			lvl_q <= 1'b0;
		end
		else if (ce)
		begin
			s1_q  <= sync_pad_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	// Row and column counters with slave reload
	always_comb
	begin
		col_d = col_q;
		row_d = row_q;
		fs_d  = 1'b0;
		if (is_slave && rise)
		begin
			row_d = act_q.row_tgt;                        // [R5] [R1]
			col_d = col_load;                             // [R5]
		end
		else if (col_q == COL_LAST)                       // [R13]
		begin
			col_d = '0;
			if (row_q == ROW_LAST)
			begin
				row_d = '0;
				fs_d  = 1'b1;
			end
			else
				row_d = row_q + TGT_W'(1);
		end
		else
			col_d = col_q + TGT_W'(1);                    // [R13]
	end

	// Master pulse generator
	always_comb
	begin
		pg_d   = pg_q;
		pcnt_d = pcnt_q;
		unique case (pg_q)
			PG_IDLE:
			begin
				if (is_master && row_q == act_q.row_tgt &&
				    col_q == act_q.col_tgt)                 // [R3]
				begin
					pg_d   = PG_DRIVE;
					pcnt_d = eff_w - PW_W'(1);              // [R4]
				end
			end
			PG_DRIVE:
			begin
				if (!is_master)                             // [R14]
					pg_d = PG_IDLE;
				else if (pcnt_q == '0)
					pg_d = PG_IDLE;
				else
					pcnt_d = pcnt_q - PW_W'(1);             // [R4]
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			row_q  <= '0;
			col_q  <= '0;
			fs_q   <= 1'b0;
			pg_q   <= PG_IDLE;
			pcnt_q <= '0;
		end
		else if (ce)
		begin
			row_q  <= row_d;
			col_q  <= col_d;
			fs_q   <= fs_d;
			pg_q   <= pg_d;
			pcnt_q <= pcnt_d;
		end
	end

	// Pad is driven only as an enabled master; released otherwise
	// Gated so the pulse never outlives the drive enable by a clock
	assign sync_pad_out  = (pg_q == PG_DRIVE) && is_master; // [R1] [R14]
	assign sync_pad_oe_n = !is_master;                    // [R1] [R14]
	assign reg_rdata     = rdata_q;
	assign row_count     = row_q;
	assign col_count     = col_q;
	assign frame_start   = fs_q;

endmodule
`default_nettype wire

// [dv/fsl_frame_sync_lock_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module fsl_lock_chk
	import fsl_pkg::*;
#(
	parameter int FRAME_W = 2200,
	parameter int FRAME_H = 1125
)
(
	// Clock and reset
	input wire logic             mclk,
	input wire logic             rst,
	input wire logic             ce,
	// Register port
	input wire logic             reg_wr,
	input wire logic             reg_rd,
	input wire logic [3:0]       reg_bank,
	input wire logic [7:0]       reg_addr,
	input wire logic [7:0]       reg_wdata,
	input wire logic [7:0]       reg_rdata,
	// Pad and timing
	input wire logic             sync_pad_in,
	input wire logic             sync_pad_out,
	input wire logic             sync_pad_oe_n,
	input wire logic [TGT_W-1:0] row_count,
	input wire logic [TGT_W-1:0] col_count,
	input wire logic             frame_start
);
	logic [2:0] steady_q;
	logic [2:0] steady_d;
	logic       pad_prev_q;
	logic       quiet;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// A reload lands clocks after a pad change; judge counters only later
	always_comb
	begin
		steady_d = steady_q;
		if (sync_pad_in != pad_prev_q)
			steady_d = 3'h0;
		else if (ce && steady_q != 3'h7)
			steady_d = steady_q + 3'h1;
	end
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			steady_q   <= 3'h0;
			pad_prev_q <= 1'b0;
		end
		else
		begin
			steady_q   <= steady_d;
			pad_prev_q <= sync_pad_in;
		end
	end
	assign quiet = steady_q >= 3'h6 && ce;
	sequence s_rise;
		!sync_pad_out ##1 sync_pad_out;
	endsequence
	sequence s_wrap;
		quiet && col_count == FRAME_W - 1;
	endsequence
	a_out_needs_drive: assert property (sync_pad_out |-> !sync_pad_oe_n)
		else $error("pad high while not driven");
	a_pulse_min: assert property (s_rise |-> (sync_pad_out || sync_pad_oe_n)[*4])
		else $error("sync pulse shorter than four clocks");
	a_pulse_max: assert property (s_rise |-> ##[1:256] !sync_pad_out)
		else $error("sync pulse never ends");
	a_col_step: assert property (quiet && col_count != FRAME_W - 1 |=>
		col_count == $past(col_count) + 13'h0001 && $stable(row_count))
		else $error("column did not advance by one");
	a_line_wrap: assert property (s_wrap |=> col_count == 13'h0000 &&
		row_count == (($past(row_count) == FRAME_H - 1) ? 13'h0000 :
		$past(row_count) + 13'h0001))
		else $error("line wrap wrong");
	a_ce_freeze: assert property (!ce |=> $stable(row_count) &&
		$stable(col_count) && $stable(sync_pad_out))
		else $error("state moved while clock enable low");
	a_fs_single: assert property (frame_start |=> !frame_start)
		else $error("frame start longer than one clock");
	a_rd_unmapped: assert property (ce && reg_rd && reg_bank > 4'h1 |=>
		reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind fsl_frame_sync_lock fsl_lock_chk #(.FRAME_W(FRAME_W), .FRAME_H(FRAME_H))
	u_chk (.mclk(mclk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_bank(reg_bank), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .sync_pad_in(sync_pad_in),
	.sync_pad_out(sync_pad_out), .sync_pad_oe_n(sync_pad_oe_n),
	.row_count(row_count), .col_count(col_count), .frame_start(frame_start));
`default_nettype wire

// [dv/fsl_far_party.sv]
`timescale 1ns/1ps
`default_nettype none
module fsl_far_party
(
	// Clock and commands
	input  wire logic       mclk,
	input  wire logic       act,
	input  wire logic       send,
	input  wire logic [7:0] width,
	// Device side of the pad
	input  wire logic       dev_out,
	input  wire logic       dev_oe_n,
	output logic            pad,
	output logic [7:0]      hi_len
);
	logic [7:0] left = 8'h00;
	logic [7:0] run = 8'h00;
	logic       last = 1'b0;
	// No pull on the pad, so undriven it shows the inverse of the last level
	assign pad = !dev_oe_n ? dev_out : act ? left != 8'h00 : ~last;
	initial hi_len = 8'h00;
	always @(posedge mclk)
	begin
		if (send)
			left <= width;
		else if (left != 8'h00)
			left <= left - 8'h01;
		if (!dev_oe_n || act)
			last <= pad;
		run <= pad ? run + 8'h01 : 8'h00;
		if (!pad && run != 8'h00)
			hi_len <= run;
	end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import fsl_pkg::*;
;
	typedef struct packed {
		logic [3:0] b;
		logic [7:0] a;
		logic       w;
		logic [7:0] d;
		logic [7:0] e;
	} fsl_row_t;
	fsl_row_t rows [17] = '{
		'{4'h0, 8'h25, 1'b0, 8'h00, 8'h00}, '{4'h1, 8'h0a, 1'b0, 8'h00, 8'h00},
		'{4'h1, 8'h50, 1'b0, 8'h00, 8'h00}, '{4'h1, 8'h51, 1'b0, 8'h00, 8'h01},
		'{4'h1, 8'h52, 1'b0, 8'h00, 8'h00}, '{4'h1, 8'h53, 1'b0, 8'h00, 8'h01},
		'{4'h1, 8'h54, 1'b0, 8'h00, 8'h10}, '{4'h1, 8'h59, 1'b0, 8'h00, 8'h00},
		'{4'h0, 8'h25, 1'b1, 8'hff, 8'h01}, '{4'h1, 8'h0a, 1'b1, 8'hff, 8'h30},
		'{4'h1, 8'h50, 1'b1, 8'he0, 8'h00}, '{4'h1, 8'h51, 1'b1, 8'haa, 8'haa},
		'{4'h1, 8'h52, 1'b1, 8'he0, 8'h00}, '{4'h1, 8'h53, 1'b1, 8'h55, 8'h55},
		'{4'h1, 8'h54, 1'b1, 8'h3c, 8'h3c}, '{4'h1, 8'h77, 1'b1, 8'h5a, 8'h00},
		'{4'h3, 8'h25, 1'b0, 8'h00, 8'h00}};
	logic             mclk = 1'b0;
	logic             rst = 1'b1;
	logic             ce = 1'b1;
	logic             reg_wr = 1'b0;
	logic             reg_rd = 1'b0;
	logic [3:0]       reg_bank = 4'h0;
	logic [7:0]       reg_addr = 8'h00;
	logic [7:0]       reg_wdata = 8'h00;
	logic             act = 1'b0;
	logic             send = 1'b0;
	logic             hit;
	logic [7:0]       reg_rdata, hi_len;
	logic             pad, sync_pad_out, sync_pad_oe_n, frame_start;
	logic [TGT_W-1:0] row_count, col_count;
	logic [25:0]      snap;
	int               mismatches = 0;
	int               num_checks = 0;
	int               fs_n = 0;
	always #2.5 mclk = ~mclk;
	always @(posedge mclk) if (frame_start === 1'b1) fs_n++;
	fsl_frame_sync_lock #(.FRAME_W(16), .FRAME_H(8)) uut (.mclk(mclk),
		.rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_bank(reg_bank), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .sync_pad_in(pad), .sync_pad_out(sync_pad_out),
		.sync_pad_oe_n(sync_pad_oe_n), .row_count(row_count),
		.col_count(col_count), .frame_start(frame_start));
	fsl_far_party u_far (.mclk(mclk), .act(act), .send(send), .width(8'h04),
		.dev_out(sync_pad_out), .dev_oe_n(sync_pad_oe_n), .pad(pad),
		.hi_len(hi_len));
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [25:0] got, input logic [25:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic wr(input logic [3:0] b, input logic [7:0] a, d);
		cyc(1);
		reg_wr = 1'b1;
		reg_bank = b;
		reg_addr = a;
		reg_wdata = d;
		cyc(1);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [3:0] b, input logic [7:0] a, e);
		cyc(1);
		reg_rd = 1'b1;
		reg_bank = b;
		reg_addr = a;
		cyc(1);
		reg_rd = 1'b0;
		chk(26'(reg_rdata), 26'(e));
	endtask
	task automatic wait_out(input logic l);
		for (int n = 0; n < 300 && sync_pad_out !== l; n++) cyc(1);
		chk(26'(sync_pad_out), 26'(l));
	endtask
	task automatic pulse(input logic [12:0] c, input logic [7:0] w);
		wait_out(1'b0);
		wait_out(1'b1);
		chk({row_count, col_count}, {13'h0001, c});
		wait_out(1'b0);
		cyc(2);
		chk(26'(hi_len), 26'(w));
	endtask
	task automatic slave(input logic exp);
		hit = 1'b0;
		for (int n = 0; n < 300 && row_count !== 13'h0006; n++) cyc(1);
		send = 1'b1;
		cyc(1);
		send = 1'b0;
		repeat (10)
		begin
			cyc(1);
			hit |= {row_count, col_count} === {13'h0003, 13'h0006};
		end
		chk(26'(hit), 26'(exp));
	endtask
	initial
	begin
		cyc(2);
		rst = 1'b0;
		cyc(200);
		chk(26'(fs_n), 26'h1);
		foreach (rows[i])
		begin
			if (rows[i].w)
				wr(rows[i].b, rows[i].a, rows[i].d);
			rd(rows[i].b, rows[i].a, rows[i].e);
		end
		wr(4'h1, 8'h51, 8'h01);
		wr(4'h1, 8'h53, 8'h01);
		wr(4'h1, 8'h54, 8'h10);
		pulse(13'h0002, 8'h10);
		wr(4'h1, 8'h54, 8'h02);
		pulse(13'h0002, 8'h04);
		wr(4'h1, 8'h54, 8'h05);
		pulse(13'h0002, 8'h05);
		for (int n = 0; n < 300 && frame_start !== 1'b1; n++) cyc(1);
		wr(4'h1, 8'h59, 8'h01);
		wr(4'h1, 8'h53, 8'h09);
		rd(4'h1, 8'h59, 8'h01);
		pulse(13'h0002, 8'h05);
		pulse(13'h000a, 8'h05);
		rd(4'h1, 8'h59, 8'h00);
		wr(4'h0, 8'h25, 8'h00);
		hit = 1'b0;
		repeat (140)
		begin
			cyc(1);
			hit |= sync_pad_out !== 1'b0 || sync_pad_oe_n !== 1'b1;
		end
		chk(26'(hit), 26'h0);
		act = 1'b1;
		wr(4'h1, 8'h0a, 8'h20);
		wr(4'h0, 8'h25, 8'h01);
		wr(4'h1, 8'h51, 8'h03);
		wr(4'h1, 8'h53, 8'h05);
		slave(1'b1);
		wr(4'h1, 8'h0a, 8'h00);
		slave(1'b0);
		snap = {row_count, col_count};
		ce = 1'b0;
		cyc(3);
		chk({row_count, col_count}, snap);
		ce = 1'b1;
		rst = 1'b1;
		cyc(2);
		chk(26'(sync_pad_oe_n), 26'h1);
		chk({row_count, col_count}, 26'h0);
		rst = 1'b0;
		rd(4'h1, 8'h54, 8'h10);
		final_report;
	end
	initial
	begin
		#100000;
		mismatches++;
		final_report;
	end
endmodule
`default_nettype wire
